// *** hdl/ttc_thermal_throttle.sv ***
// Thermal throttle controller with Avalon-MM register slave
// Functional notes
// - Cool by clock gating or operating-point change
// - Automatic activation overrides on-demand activation
// - Software register selects automatic method
// - Automatic engages only at maximum die temperature
// - Lower point when hot, then restore request
// - Higher software request waits for episode end
// - Lower software request applies at once
// - Automatic modulation fixed at half duty
// - Stop modulation when temperature is normal
// - Hysteresis between engage and release
// - On-demand bit four engages immediately
// - Bits three to one set duty
// - Hot output low when above trip
// - Snooping and interrupt latching stay alive until a trip
// - Optional interrupt on hot output edges
// - No new hot assertion while clocks stopped
// - Asserted hot held through clock-stopped state
// - Catastrophic temperature trips and shuts down
// - Trip needs no processor activity or bus
// - Activation temperature fixed and invisible
//
// The Avalon-MM register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module ttc_thermal_throttle #(
  parameter int MOD_STEP_CYC = ttc_pkg::MOD_STEP_CYC,
  parameter logic [7:0] THERM_OP = ttc_pkg::THERM_OP
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire ttc_pkg::ttc_sensor_t sensor_in,
  input wire logic clocks_stopped,
  output logic core_clk_en,
  output logic snoop_irq_latch_en,
  output ttc_pkg::ttc_op_t op_out,
  output logic die_hot_out_n_o,
  output logic die_hot_out_n_oe,
  output logic catastrophic_trip_out_n,
  output logic hot_irq
);

  if (MOD_STEP_CYC < 1 || MOD_STEP_CYC > 65535) begin : g_chk
    $error("MOD_STEP_CYC out of range");
  end

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Sensor synchroniser
  ttc_pkg::ttc_sensor_t sens_s1_reg;
  ttc_pkg::ttc_sensor_t sens_s2_reg;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sens_s1_reg <= '0;
      sens_s2_reg <= '0;
    end else begin
      sens_s1_reg <= sensor_in;
      sens_s2_reg <= sens_s1_reg;
    end
  end

  // Registers
  logic [31:0] ctrl_reg;
  logic [31:0] odctrl_reg;
  logic [7:0] last_req_reg;
  logic [7:0] cur_op_reg;
  logic ev_rise_reg;
  logic ev_fall_reg;
  logic hot_state_reg;
  logic hot_pin_reg;
  logic trip_reg;
  logic [2:0] phase_reg;
  logic [15:0] step_cnt_reg;
  logic core_clk_en_reg;
  logic op_change_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  // Bus decode: one wait cycle, answer on the second
  wire logic req = avs_read | avs_write;
  wire logic hit_ctrl = avs_address == ttc_pkg::OFF_CTRL;
  wire logic hit_od = avs_address == ttc_pkg::OFF_ODCTRL;
  wire logic hit_opreq = avs_address == ttc_pkg::OFF_OPREQ;
  wire logic hit_stat = avs_address == ttc_pkg::OFF_STATUS;
  wire logic hit_ev = avs_address == ttc_pkg::OFF_EVENT;
  wire logic wr_go = avs_write & ack_reg;
  assign avs_waitrequest = req & ~ack_reg;

  wire logic auto_en = ctrl_reg[ttc_pkg::CTRL_AUTO_EN];
  wire ttc_pkg::ttc_method_t method = ttc_pkg::ttc_method_t'(ctrl_reg[ttc_pkg::CTRL_METHOD]);
  wire logic od_en = odctrl_reg[ttc_pkg::OD_EN];
  wire logic [2:0] od_duty = odctrl_reg[ttc_pkg::OD_DUTY_HI:ttc_pkg::OD_DUTY_LO];

  // Episode detection; trip point lives only in the sensor
  wire logic auto_active = auto_en & hot_state_reg;
  wire logic auto_clkmod = auto_active & (method == ttc_pkg::TTC_METH_CLKMOD);
  wire logic auto_oppt = auto_active & (method == ttc_pkg::TTC_METH_OPPT);
  wire logic od_active = od_en & ~auto_active;
  wire logic mod_active = auto_clkmod | od_active;
  wire logic engine_active = auto_active | od_en;

  // Reserved duty code zero runs at half duty
  wire logic [2:0] od_on_steps = (od_duty == 3'h0) ? ttc_pkg::OD_DUTY_DEFAULT : od_duty;
  wire logic [2:0] on_steps = auto_clkmod ? ttc_pkg::AUTO_ON_STEPS : od_on_steps;
  wire logic step_end = step_cnt_reg == 16'(MOD_STEP_CYC - 1);
  wire logic clk_on_next = trip_reg ? 1'b0 : (mod_active ? (phase_reg < on_steps) : 1'b1);

  // Operating-point target
  wire logic [7:0] wr_op = avs_writedata[7:0];
  wire logic [7:0] req_next = (wr_go & hit_opreq & avs_byteenable[0]) ? wr_op : last_req_reg;
  wire logic [7:0] op_next = (auto_oppt && req_next > THERM_OP) ? THERM_OP : req_next;
  wire logic defer = auto_oppt & (last_req_reg > THERM_OP);

  // Hot indication and its edges
  wire logic hot_set = sens_s2_reg.at_max;
  wire logic hot_clr = sens_s2_reg.below_release;
  wire logic hot_state_next = hot_set ? 1'b1 : (hot_clr ? 1'b0 : hot_state_reg);
  wire logic hot_pin_next = clocks_stopped ? (hot_pin_reg & hot_state_reg) | (hot_pin_reg & clocks_stopped)
                                           : hot_state_reg;
  wire logic hot_rise = hot_pin_next & ~hot_pin_reg;
  wire logic hot_fall = ~hot_pin_next & hot_pin_reg;
  wire logic clr_rise = wr_go & hit_ev & avs_byteenable[0] & avs_writedata[ttc_pkg::EV_RISE];
  wire logic clr_fall = wr_go & hit_ev & avs_byteenable[0] & avs_writedata[ttc_pkg::EV_FALL];
  wire logic ev_rise_next = hot_rise | (ev_rise_reg & ~clr_rise);
  wire logic ev_fall_next = hot_fall | (ev_fall_reg & ~clr_fall);

  wire logic [31:0] status_word = {16'h0000, cur_op_reg, 4'h0, defer, trip_reg, hot_pin_reg, engine_active};
  wire logic [31:0] rdata_next = hit_ctrl ? ctrl_reg :
                                 hit_od ? odctrl_reg :
                                 hit_opreq ? {24'h00_0000, last_req_reg} :
                                 hit_stat ? status_word :
                                 hit_ev ? {30'h0000_0000, ev_fall_reg, ev_rise_reg} : 32'h0000_0000;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (avs_read & ~ack_reg) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl_reg <= ttc_pkg::CTRL_RESET;
      odctrl_reg <= ttc_pkg::ODCTRL_RESET;
    end else if (wr_go) begin
      if (hit_ctrl) begin
        ctrl_reg <= be_merge(ctrl_reg, avs_writedata, avs_byteenable) & 32'h0000_0303;
      end
      if (hit_od) begin
        odctrl_reg <= be_merge(odctrl_reg, avs_writedata, avs_byteenable) & 32'h0000_001E;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      last_req_reg <= ttc_pkg::OP_RESET;
      cur_op_reg <= ttc_pkg::OP_RESET;
      op_change_reg <= 1'b0;
    end else begin
      last_req_reg <= req_next;
      cur_op_reg <= op_next;
      op_change_reg <= op_next != cur_op_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      hot_state_reg <= 1'b0;
      hot_pin_reg <= 1'b0;
      ev_rise_reg <= 1'b0;
      ev_fall_reg <= 1'b0;
    end else begin
      hot_state_reg <= hot_state_next;
      hot_pin_reg <= hot_pin_next;
      ev_rise_reg <= ev_rise_next;
      ev_fall_reg <= ev_fall_next;
    end
  end

  // Trip latches until reset, independent of all settings
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      trip_reg <= 1'b0;
    end else if (sens_s2_reg.catastrophic) begin
      trip_reg <= 1'b1;
    end
  end

  // Modulation period counted in sys_clk cycles, gated or not, so it shrinks as the clock speeds up
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      step_cnt_reg <= 16'h0000;
      phase_reg <= 3'h0;
      core_clk_en_reg <= 1'b1;
    end else begin
      core_clk_en_reg <= clk_on_next;
      if (!mod_active) begin
        step_cnt_reg <= 16'h0000;
        phase_reg <= 3'h0;
      end else if (step_end) begin
        step_cnt_reg <= 16'h0000;
        phase_reg <= phase_reg + 3'h1;
      end else begin
        step_cnt_reg <= step_cnt_reg + 16'h0001;
      end
    end
  end

  assign avs_readdata = rdata_reg;
  assign core_clk_en = core_clk_en_reg;
  // Snoop and interrupt capture run on ungated clocks until a trip
  assign snoop_irq_latch_en = ~trip_reg;
  assign op_out.point = cur_op_reg;
  assign op_out.change = op_change_reg;
  assign die_hot_out_n_o = 1'b0;
  assign die_hot_out_n_oe = hot_pin_reg;
  // Platform must cut core supply after this falls
  assign catastrophic_trip_out_n = ~trip_reg;
  assign hot_irq = (ev_rise_reg & ctrl_reg[ttc_pkg::CTRL_IRQ_RISE]) |
                   (ev_fall_reg & ctrl_reg[ttc_pkg::CTRL_IRQ_FALL]);

  // Checks
  sequence s_cat_seen;
    sens_s2_reg.catastrophic;
  endsequence
  sequence s_trip_held;
    !catastrophic_trip_out_n [*8];
  endsequence

  property p_trip;
    @(posedge sys_clk) disable iff (!nrst) s_cat_seen |=> s_trip_held;
  endproperty
  a_trip: assert property (p_trip) else $error("trip not held");

  property p_trip_stop;
    @(posedge sys_clk) disable iff (!nrst) !catastrophic_trip_out_n |=> !core_clk_en;
  endproperty
  a_trip_stop: assert property (p_trip_stop) else $error("clocks run after trip");

  property p_hot_follow;
    @(posedge sys_clk) disable iff (!nrst) hot_set && !clocks_stopped ##1 !clocks_stopped |=> die_hot_out_n_oe;
  endproperty
  a_hot_follow: assert property (p_hot_follow) else $error("hot not shown");

  property p_no_new_hot;
    @(posedge sys_clk) disable iff (!nrst) clocks_stopped && !die_hot_out_n_oe |=> !die_hot_out_n_oe;
  endproperty
  a_no_new_hot: assert property (p_no_new_hot) else $error("hot raised while stopped");

  property p_hold_hot;
    @(posedge sys_clk) disable iff (!nrst) clocks_stopped && die_hot_out_n_oe |=> die_hot_out_n_oe;
  endproperty
  a_hold_hot: assert property (p_hold_hot) else $error("hot dropped while stopped");

  property p_auto_half;
    @(posedge sys_clk) disable iff (!nrst) auto_clkmod && !trip_reg && od_en |-> on_steps == 3'h4;
  endproperty
  a_auto_half: assert property (p_auto_half) else $error("automatic duty not half");

  property p_gate_phase;
    @(posedge sys_clk) disable iff (!nrst) auto_clkmod && !trip_reg |=> core_clk_en == ($past(phase_reg) < 3'h4);
  endproperty
  a_gate_phase: assert property (p_gate_phase) else $error("gate phase wrong");

  property p_restore;
    @(posedge sys_clk) disable iff (!nrst) $fell(auto_oppt) && !avs_write |=> cur_op_reg == last_req_reg;
  endproperty
  a_restore: assert property (p_restore) else $error("point not restored");

  property p_defer;
    @(posedge sys_clk) disable iff (!nrst) auto_oppt && req_next > THERM_OP |=> cur_op_reg == THERM_OP;
  endproperty
  a_defer: assert property (p_defer) else $error("higher request not deferred");

  property p_lower;
    @(posedge sys_clk) disable iff (!nrst) auto_oppt && req_next <= THERM_OP |=> cur_op_reg == $past(req_next);
  endproperty
  a_lower: assert property (p_lower) else $error("lower request not taken");

  property p_release;
    @(posedge sys_clk) disable iff (!nrst) !od_en && !hot_state_reg && !trip_reg |=> core_clk_en;
  endproperty
  a_release: assert property (p_release) else $error("modulation persists");

  property p_hyst;
    @(posedge sys_clk) disable iff (!nrst) !hot_set && !hot_clr |=> hot_state_reg == $past(hot_state_reg);
  endproperty
  a_hyst: assert property (p_hyst) else $error("hysteresis lost");

  property p_change;
    @(posedge sys_clk) disable iff (!nrst) op_out.change == (cur_op_reg != $past(cur_op_reg));
  endproperty
  a_change: assert property (p_change) else $error("point change pulse wrong");

  property p_od_duty;
    @(posedge sys_clk) disable iff (!nrst)
      od_active && !trip_reg |=> core_clk_en == ($past(phase_reg) < $past(od_on_steps));
  endproperty
  a_od_duty: assert property (p_od_duty) else $error("on-demand duty wrong");

  property p_auto_over_od;
    @(posedge sys_clk) disable iff (!nrst) auto_oppt && od_en && !trip_reg |=> core_clk_en;
  endproperty
  a_auto_over_od: assert property (p_auto_over_od) else $error("on-demand gating during episode");

  property p_idle_point;
    @(posedge sys_clk) disable iff (!nrst) !hot_state_reg |=> cur_op_reg == $past(req_next);
  endproperty
  a_idle_point: assert property (p_idle_point) else $error("point limited while cool");

  property p_oppt_point;
    @(posedge sys_clk) disable iff (!nrst) auto_oppt |=> cur_op_reg <= THERM_OP;
  endproperty
  a_oppt_point: assert property (p_oppt_point) else $error("point above thermal target");

  property p_oppt_clk;
    @(posedge sys_clk) disable iff (!nrst) auto_oppt && !trip_reg |=> core_clk_en;
  endproperty
  a_oppt_clk: assert property (p_oppt_clk) else $error("clocks gated in point method");

  property p_hot_pin;
    @(posedge sys_clk) disable iff (!nrst) !clocks_stopped |=> die_hot_out_n_oe == $past(hot_state_reg);
  endproperty
  a_hot_pin: assert property (p_hot_pin) else $error("hot pin not following state");

  property p_irq_rise;
    @(posedge sys_clk) disable iff (!nrst) $rose(die_hot_out_n_oe) && ctrl_reg[ttc_pkg::CTRL_IRQ_RISE] |-> hot_irq;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("no interrupt on hot rise");

  property p_irq_fall;
    @(posedge sys_clk) disable iff (!nrst) $fell(die_hot_out_n_oe) && ctrl_reg[ttc_pkg::CTRL_IRQ_FALL] |-> hot_irq;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("no interrupt on hot fall");

  property p_snoop;
    @(posedge sys_clk) disable iff (!nrst) !trip_reg |-> snoop_irq_latch_en;
  endproperty
  a_snoop: assert property (p_snoop) else $error("snoop latch disabled");

  property p_trip_stopped;
    @(posedge sys_clk) disable iff (!nrst) clocks_stopped ##0 s_cat_seen |=> !catastrophic_trip_out_n;
  endproperty
  a_trip_stopped: assert property (p_trip_stopped) else $error("trip waits for activity");

  property p_hot_set;
    @(posedge sys_clk) disable iff (!nrst) hot_set |=> hot_state_reg;
  endproperty
  a_hot_set: assert property (p_hot_set) else $error("hot state not set");

  property p_hot_clr;
    @(posedge sys_clk) disable iff (!nrst) hot_clr && !hot_set |=> !hot_state_reg;
  endproperty
  a_hot_clr: assert property (p_hot_clr) else $error("hot state not cleared");

endmodule // ttc_thermal_throttle

// *** hdl/ttc_pkg.sv ***
// Constants, register map and carrier types of the thermal throttle controller
package ttc_pkg;
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_ODCTRL = 5'h04;
  localparam logic [4:0] OFF_OPREQ = 5'h08;
  localparam logic [4:0] OFF_STATUS = 5'h0C;
  localparam logic [4:0] OFF_EVENT = 5'h10;
  // CTRL fields
  localparam int CTRL_AUTO_EN = 0;
  localparam int CTRL_METHOD = 1;
  localparam int CTRL_IRQ_RISE = 8;
  localparam int CTRL_IRQ_FALL = 9;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
  // ODCTRL fields
  localparam int OD_DUTY_LO = 1;
  localparam int OD_DUTY_HI = 3;
  localparam int OD_EN = 4;
  localparam logic [31:0] ODCTRL_RESET = 32'h0000_0000;
  // STATUS fields
  localparam int ST_ACTIVE = 0;
  localparam int ST_HOT = 1;
  localparam int ST_TRIP = 2;
  localparam int ST_DEFER = 3;
  localparam int ST_OP_LO = 8;
  // EVENT fields, write one to clear
  localparam int EV_RISE = 0;
  localparam int EV_FALL = 1;
  // Clock modulation: eight steps of 12.5 %
  localparam int MOD_STEPS = 8;
  localparam logic [2:0] AUTO_ON_STEPS = 3'h4;
  localparam logic [2:0] OD_DUTY_DEFAULT = 3'h4;
  localparam int MOD_STEP_CYC = 16;
  localparam int OP_W = 8;
  localparam logic [7:0] OP_RESET = 8'hFF;
  localparam logic [7:0] THERM_OP = 8'h10;

  typedef enum logic [0:0] {
    TTC_METH_CLKMOD = 1'b0,
    TTC_METH_OPPT = 1'b1
  } ttc_method_t;

  // Digital levels from the on-die sensor
  typedef struct packed {
    logic at_max;
    logic below_release;
    logic catastrophic;
  } ttc_sensor_t;

  // Operating-point request to the clock and voltage control
  typedef struct packed {
    logic [7:0] point;
    logic change;
  } ttc_op_t;
endpackage

// *** tb/ttc_platform_model.sv ***
// Platform model: die temperature levels to sensor, core supply cut on trip
`timescale 1ns/1ps
module ttc_platform_model (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [1:0] temp_level,
  input wire logic catastrophic_trip_out_n,
  output ttc_pkg::ttc_sensor_t sensor_in,
  output logic core_power_on
);
  // Level 0 cool, 1 inside hysteresis band, 2 at maximum, 3 catastrophic
  assign sensor_in.at_max = temp_level[1];
  assign sensor_in.below_release = (temp_level == 2'h0);
  assign sensor_in.catastrophic = (temp_level == 2'h3);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      core_power_on <= 1'b1;
    end else if (!catastrophic_trip_out_n) begin
      core_power_on <= 1'b0;
    end
  end
endmodule // ttc_platform_model

// *** tb/thermal_throttle_controller_tb_top.sv ***
// Self-checking bench of the thermal throttle controller
`timescale 1ns/1ps
module thermal_throttle_controller_tb_top;
  localparam int STEP = 4;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  ttc_pkg::ttc_sensor_t sensor_in;
  logic clocks_stopped = 1'b0;
  logic core_clk_en, snoop_irq_latch_en, die_hot_out_n_o, die_hot_out_n_oe, catastrophic_trip_out_n, hot_irq;
  ttc_pkg::ttc_op_t op_out;
  logic [1:0] temp_level = 2'd0;
  logic core_power_on;
  int errors = 0;
  int n_compared = 0;
  int c;
  logic [31:0] rd;
  // Open-drain pin with pull-up
  wire die_hot_n = die_hot_out_n_oe ? die_hot_out_n_o : 1'b1;

  always #25 sys_clk = ~sys_clk;

  ttc_thermal_throttle #(.MOD_STEP_CYC(STEP), .THERM_OP(8'h10)) u_ttc_thermal_throttle (
    .sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sensor_in(sensor_in), .clocks_stopped(clocks_stopped),
    .core_clk_en(core_clk_en), .snoop_irq_latch_en(snoop_irq_latch_en), .op_out(op_out),
    .die_hot_out_n_o(die_hot_out_n_o), .die_hot_out_n_oe(die_hot_out_n_oe),
    .catastrophic_trip_out_n(catastrophic_trip_out_n), .hot_irq(hot_irq));

  ttc_platform_model u_ttc_platform_model (.sys_clk(sys_clk), .nrst(nrst), .temp_level(temp_level),
    .catastrophic_trip_out_n(catastrophic_trip_out_n), .sensor_in(sensor_in), .core_power_on(core_power_on));

  task automatic complete_run();
    $display("counts: %0d mismatches in %0d comparisons", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic end_test(input string name);
    $display("test %s finished, mismatches so far %0d", name, errors);
  endtask

  // Avalon access: hold request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 50) begin
      errors++;
      $display("mismatch waitrequest expected 0 seen 1");
      complete_run();
    end
  endtask

  task automatic wait_hot(input logic v);
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      if (die_hot_out_n_oe === v) break;
    end
    if (i == 40) begin
      errors++;
      $display("mismatch hot pin enable expected %b seen %b", v, die_hot_out_n_oe);
      complete_run();
    end
  endtask

  task automatic count_on(input int n);
    c = 0;
    repeat (n) begin
      @(posedge sys_clk);
      if (core_clk_en === 1'b1) c++;
    end
  endtask

  initial begin
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    bus(1'b0, ttc_pkg::OFF_CTRL, 32'h0000_0000, rd);
    cmp_word("ctrl reset", ttc_pkg::CTRL_RESET, rd);
    bus(1'b0, ttc_pkg::OFF_ODCTRL, 32'h0000_0000, rd);
    cmp_word("odctrl reset", ttc_pkg::ODCTRL_RESET, rd);
    bus(1'b0, ttc_pkg::OFF_STATUS, 32'h0000_0000, rd);
    cmp_word("status reset", 32'h0000_FF00, rd);
    bus(1'b1, 5'h14, 32'hFFFF_FFFF, rd);
    bus(1'b0, 5'h14, 32'h0000_0000, rd);
    cmp_word("unmapped read", 32'h0000_0000, rd);
    cmp_bit("hot pin idle", 1'b1, die_hot_n);
    end_test("reset");
    // Operating-point method with edge interrupts
    bus(1'b1, ttc_pkg::OFF_CTRL, 32'h0000_0303, rd);
    bus(1'b1, ttc_pkg::OFF_ODCTRL, 32'h0000_0012, rd);
    bus(1'b1, ttc_pkg::OFF_OPREQ, 32'h0000_0030, rd);
    temp_level <= 2'd2;
    wait_hot(1'b1);
    repeat (2) @(posedge sys_clk);
    cmp_bit("hot pin", 1'b0, die_hot_n);
    cmp_word("thermal point", 32'h0000_0010, {24'h00_0000, op_out.point});
    cmp_bit("clock kept", 1'b1, core_clk_en);
    cmp_bit("snoop latch", 1'b1, snoop_irq_latch_en);
    cmp_bit("rise irq", 1'b1, hot_irq);
    bus(1'b0, ttc_pkg::OFF_EVENT, 32'h0000_0000, rd);
    cmp_word("rise event", 32'h0000_0001, rd);
    bus(1'b1, ttc_pkg::OFF_EVENT, 32'h0000_0001, rd);
    bus(1'b1, ttc_pkg::OFF_OPREQ, 32'h0000_0020, rd);
    repeat (2) @(posedge sys_clk);
    cmp_bit("irq cleared", 1'b0, hot_irq);
    cmp_word("higher deferred", 32'h0000_0010, {24'h00_0000, op_out.point});
    bus(1'b0, ttc_pkg::OFF_STATUS, 32'h0000_0000, rd);
    cmp_word("status deferred", 32'h0000_100B, rd);
    bus(1'b1, ttc_pkg::OFF_OPREQ, 32'h0000_0008, rd);
    @(posedge sys_clk);
    cmp_bit("change pulse", 1'b1, op_out.change);
    @(posedge sys_clk);
    cmp_bit("change cleared", 1'b0, op_out.change);
    cmp_word("lower direct", 32'h0000_0008, {24'h00_0000, op_out.point});
    bus(1'b1, ttc_pkg::OFF_OPREQ, 32'h0000_0040, rd);
    temp_level <= 2'd1;
    repeat (10) @(posedge sys_clk);
    cmp_bit("hysteresis hold", 1'b1, die_hot_out_n_oe);
    temp_level <= 2'd0;
    wait_hot(1'b0);
    repeat (2) @(posedge sys_clk);
    cmp_word("restored point", 32'h0000_0040, {24'h00_0000, op_out.point});
    bus(1'b0, ttc_pkg::OFF_EVENT, 32'h0000_0000, rd);
    cmp_word("fall event", 32'h0000_0002, rd);
    bus(1'b1, ttc_pkg::OFF_EVENT, 32'h0000_0003, rd);
    end_test("operating point");
    // Clock modulation: on-demand alone, then automatic takes over
    bus(1'b1, ttc_pkg::OFF_CTRL, 32'h0000_0001, rd);
    bus(1'b1, ttc_pkg::OFF_ODCTRL, 32'h0000_0014, rd);
    repeat (8 * STEP) @(posedge sys_clk);
    count_on(8 * STEP);
    cmp_word("ondemand duty", 32'(2 * STEP), 32'(c));
    temp_level <= 2'd2;
    wait_hot(1'b1);
    repeat (8 * STEP) @(posedge sys_clk);
    count_on(8 * STEP);
    cmp_word("auto duty", 32'(4 * STEP), 32'(c));
    temp_level <= 2'd0;
    wait_hot(1'b0);
    bus(1'b1, ttc_pkg::OFF_ODCTRL, 32'h0000_0000, rd);
    repeat (4) @(posedge sys_clk);
    count_on(8 * STEP);
    cmp_word("modulation stopped", 32'(8 * STEP), 32'(c));
    end_test("clock modulation");
    for (int d = 0; d < 8; d++) begin
      bus(1'b1, ttc_pkg::OFF_ODCTRL, 32'h0000_0010 | (32'(d) << 1), rd);
      repeat (8 * STEP) @(posedge sys_clk);
      count_on(8 * STEP);
      cmp_word("duty step", 32'(((d == 0) ? 4 : d) * STEP), 32'(c));
    end
    bus(1'b1, ttc_pkg::OFF_ODCTRL, 32'h0000_0000, rd);
    end_test("duty table");
    // Low-power state with clocks stopped
    clocks_stopped <= 1'b1;
    temp_level <= 2'd2;
    repeat (10) @(posedge sys_clk);
    cmp_bit("no new hot", 1'b0, die_hot_out_n_oe);
    clocks_stopped <= 1'b0;
    wait_hot(1'b1);
    clocks_stopped <= 1'b1;
    temp_level <= 2'd0;
    repeat (10) @(posedge sys_clk);
    cmp_bit("hot held", 1'b1, die_hot_out_n_oe);
    clocks_stopped <= 1'b0;
    wait_hot(1'b0);
    end_test("clocks stopped");
    // Catastrophic trip with both modes off and the core idle
    bus(1'b1, ttc_pkg::OFF_CTRL, 32'h0000_0000, rd);
    clocks_stopped <= 1'b1;
    temp_level <= 2'd3;
    for (c = 0; c < 40 && catastrophic_trip_out_n !== 1'b0; c++) @(posedge sys_clk);
    cmp_bit("trip asserted", 1'b0, catastrophic_trip_out_n);
    repeat (2) @(posedge sys_clk);
    cmp_bit("core stopped", 1'b0, core_clk_en);
    cmp_bit("no bus cycle", 1'b0, avs_waitrequest);
    cmp_bit("supply removed", 1'b0, core_power_on);
    end_test("trip");
    complete_run();
  end
endmodule // thermal_throttle_controller_tb_top
